/* alwin_ctrl.sv */
// Alarm window lock, alert clear and alert status bits of a temperature sensor configuration register
//
// Function
// - Alarm window lock low lets upper/lower trip writes through; high ignores them.
// - Alarm window lock resets to 0, reads 1 once set, only power-on reset clears.
// - One plain register write sets the alarm window lock.
// - Writing 1 to clear-alert drops a latched interrupt-mode alert; comparator mode unaffected.
// - Clear-alert bit is write-only and always reads 0.
// - With alert response select 0, an alert response command also clears the alert.
// - Alert status bit reads 1 while the alert output is asserted, else 0.
// - Writes to the alert status bit are ignored.
// - Temperature readout carries the live per-threshold trip flags for the host to read.
// - Either lock set: shutdown may be cleared but not set.
// - Either lock set: alert output enable and polarity writes are ignored.
// - Alarm window lock set: critical-only alert mode writes are ignored.
//
// Design decisions made here: the register addresses and strobed register access.
`include "alwin_params.svh"
`timescale 1ns/1ns
module alwin_ctrl (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire alwin_pkg::alwin_trip_t trip,
   input wire logic [12:0] temp_value,
   input wire logic ara_detect,
   output logic alert_out,
   output logic alert_oe,
   output logic irq
);

   // ----------------------------------------
   // Request bundle
   // ----------------------------------------
   alwin_pkg::alwin_req_t req;

   always_comb begin
      req.addr = addr;
      req.wdata = wdata;
      req.wr = wr;
      req.rd = rd;
   end

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   logic wr_cfg;
   logic wr_upper;
   logic wr_lower;
   logic wr_crit;
   logic wr_smbus;
   logic wr_irq_status;
   logic wr_irq_mask;

   assign wr_cfg = req.wr && (req.addr == `ALWIN_OFS_CONFIG);
   assign wr_upper = req.wr && (req.addr == `ALWIN_OFS_UPPER);
   assign wr_lower = req.wr && (req.addr == `ALWIN_OFS_LOWER);
   assign wr_crit = req.wr && (req.addr == `ALWIN_OFS_CRIT);
   assign wr_smbus = req.wr && (req.addr == `ALWIN_OFS_SMBUS);
   assign wr_irq_status = req.wr && (req.addr == `ALWIN_OFS_IRQ_STATUS);
   assign wr_irq_mask = req.wr && (req.addr == `ALWIN_OFS_IRQ_MASK);

   // ----------------------------------------
   // Configuration bits
   // ----------------------------------------
   alwin_pkg::alwin_cfg_t cfg;
   alwin_pkg::alwin_cfg_t next_cfg;
   logic any_lock;
   logic cfg_refused;

   assign any_lock = cfg.crit_lock | cfg.win_lock;

   // Each field is judged on its own so a refused field never blocks its neighbours
   always_comb begin
      next_cfg = cfg;
      cfg_refused = 1'b0;
      if (wr_cfg) begin
         if (req.wdata[`ALWIN_CFG_WIN_LOCK]) begin
            next_cfg.win_lock = 1'b1;
         end
         if (req.wdata[`ALWIN_CFG_CRIT_LOCK]) begin
            next_cfg.crit_lock = 1'b1;
         end
         if (!req.wdata[`ALWIN_CFG_SHUTDOWN]) begin
            next_cfg.shutdown = 1'b0;
         end else if (!any_lock) begin
            next_cfg.shutdown = 1'b1;
         end else if (!cfg.shutdown) begin
            cfg_refused = 1'b1;
         end
         if (!any_lock) begin
            next_cfg.out_en = req.wdata[`ALWIN_CFG_OUT_EN];
            next_cfg.polarity = req.wdata[`ALWIN_CFG_POLARITY];
         end else if ((req.wdata[`ALWIN_CFG_OUT_EN] != cfg.out_en) ||
                      (req.wdata[`ALWIN_CFG_POLARITY] != cfg.polarity)) begin
            cfg_refused = 1'b1;
         end
         if (!cfg.win_lock) begin
            next_cfg.crit_only = req.wdata[`ALWIN_CFG_CRIT_ONLY];
         end else if (req.wdata[`ALWIN_CFG_CRIT_ONLY] != cfg.crit_only) begin
            cfg_refused = 1'b1;
         end
         next_cfg.int_mode = req.wdata[`ALWIN_CFG_INT_MODE];
      end
   end

   // Only reset brings the locks back to zero; no write path clears them
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg <= '0;
      end else if (ce) begin
         cfg <= next_cfg;
      end
   end

   // ----------------------------------------
   // Trip registers
   // ----------------------------------------
   logic [15:0] upper_trip;
   logic [15:0] lower_trip;
   logic [15:0] crit_trip;
   logic trip_refused;

   assign trip_refused = ((wr_upper || wr_lower) && cfg.win_lock) || (wr_crit && cfg.crit_lock);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         upper_trip <= `ALWIN_RST_TRIP;
      end else if (ce && wr_upper && !cfg.win_lock) begin
         upper_trip <= req.wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lower_trip <= `ALWIN_RST_TRIP;
      end else if (ce && wr_lower && !cfg.win_lock) begin
         lower_trip <= req.wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         crit_trip <= `ALWIN_RST_TRIP;
      end else if (ce && wr_crit && !cfg.crit_lock) begin
         crit_trip <= req.wdata;
      end
   end

   // ----------------------------------------
   // Alert response select
   // ----------------------------------------
   logic ara_sel;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ara_sel <= `ALWIN_RST_SMBUS;
      end else if (ce && wr_smbus) begin
         ara_sel <= req.wdata[`ALWIN_SMBUS_ARA_SEL];
      end
   end

   // ----------------------------------------
   // Alert response command from the serial front end
   // ----------------------------------------
   logic ara_level;
   logic ara_prev;
   logic ara_clear;

   alwin_sync u_ara_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .ce(ce),
      .async_in(ara_detect),
      .level(ara_level)
   );

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ara_prev <= 1'b0;
      end else if (ce) begin
         ara_prev <= ara_level;
      end
   end

   assign ara_clear = ara_level && !ara_prev && !ara_sel;

   // ----------------------------------------
   // Alert condition
   // ----------------------------------------
   logic window_cond;
   logic cond;
   logic window_prev;
   logic clear_req;
   logic event_latch;
   logic next_event_latch;
   logic alert_active;
   logic latch_rise;

   assign window_cond = !cfg.shutdown && !cfg.crit_only && (trip.above_upper || trip.below_lower);
   assign cond = window_cond || (!cfg.shutdown && trip.above_crit);
   assign clear_req = (wr_cfg && req.wdata[`ALWIN_CFG_CLEAR]) || ara_clear;
   assign latch_rise = cfg.int_mode && window_cond && !window_prev;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         window_prev <= 1'b0;
      end else if (ce) begin
         window_prev <= window_cond;
      end
   end

   // A fresh trip in the clearing cycle wins over the clear
   always_comb begin
      next_event_latch = event_latch;
      if (!cfg.int_mode) begin
         next_event_latch = 1'b0;
      end else if (latch_rise) begin
         next_event_latch = 1'b1;
      end else if (clear_req) begin
         next_event_latch = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         event_latch <= 1'b0;
      end else if (ce) begin
         event_latch <= next_event_latch;
      end
   end

   // Interrupt mode latches window events; critical stays a live level in both modes
   assign alert_active = cfg.out_en &&
      (cfg.int_mode ? (event_latch || (!cfg.shutdown && trip.above_crit)) : cond);

   // ----------------------------------------
   // Alert pin, open drain
   // ----------------------------------------
   logic alert_state;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         alert_state <= 1'b0;
      end else if (ce) begin
         alert_state <= alert_active;
      end
   end

   // Active low pulls the line while asserted; active high pulls it while idle
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         alert_oe <= 1'b0;
      end else if (ce) begin
         alert_oe <= cfg.out_en && (alert_active ^ cfg.polarity);
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         alert_out <= 1'b0;
      end else if (ce) begin
         alert_out <= 1'b0;
      end
   end

   // ----------------------------------------
   // Interrupt bank
   // ----------------------------------------
   logic [2:0] irq_set;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;

   always_comb begin
      irq_set = '0;
      irq_set[`ALWIN_IRQ_ALERT] = alert_active && !alert_state;
      irq_set[`ALWIN_IRQ_REFUSED] = cfg_refused || trip_refused;
      irq_set[`ALWIN_IRQ_CLEARED] = event_latch && !next_event_latch;
   end

   alwin_irq #(
      .W(`ALWIN_IRQ_W)
   ) u_irq (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .ce(ce),
      .event_set(irq_set),
      .wr_status(wr_irq_status),
      .wr_mask(wr_irq_mask),
      .wdata(req.wdata[2:0]),
      .status(irq_status),
      .mask(irq_mask),
      .irq(irq)
   );

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   logic [15:0] next_rdata;

   always_comb begin
      next_rdata = '0;
      unique case (req.addr)
         `ALWIN_OFS_CONFIG: begin
            next_rdata[`ALWIN_CFG_SHUTDOWN] = cfg.shutdown;
            next_rdata[`ALWIN_CFG_CRIT_LOCK] = cfg.crit_lock;
            next_rdata[`ALWIN_CFG_WIN_LOCK] = cfg.win_lock;
            next_rdata[`ALWIN_CFG_CLEAR] = 1'b0;
            next_rdata[`ALWIN_CFG_STATE] = alert_state;
            next_rdata[`ALWIN_CFG_OUT_EN] = cfg.out_en;
            next_rdata[`ALWIN_CFG_CRIT_ONLY] = cfg.crit_only;
            next_rdata[`ALWIN_CFG_POLARITY] = cfg.polarity;
            next_rdata[`ALWIN_CFG_INT_MODE] = cfg.int_mode;
         end
         `ALWIN_OFS_UPPER: begin
            next_rdata = upper_trip;
         end
         `ALWIN_OFS_LOWER: begin
            next_rdata = lower_trip;
         end
         `ALWIN_OFS_CRIT: begin
            next_rdata = crit_trip;
         end
         `ALWIN_OFS_TEMP: begin
            next_rdata[12:0] = temp_value;
            next_rdata[`ALWIN_TEMP_ABOVE_CRIT] = trip.above_crit;
            next_rdata[`ALWIN_TEMP_ABOVE_UPPER] = trip.above_upper;
            next_rdata[`ALWIN_TEMP_BELOW_LOWER] = trip.below_lower;
         end
         `ALWIN_OFS_SMBUS: begin
            next_rdata[`ALWIN_SMBUS_ARA_SEL] = ara_sel;
         end
         `ALWIN_OFS_IRQ_STATUS: begin
            next_rdata[2:0] = irq_status;
         end
         `ALWIN_OFS_IRQ_MASK: begin
            next_rdata[2:0] = irq_mask;
         end
         default: begin
            next_rdata = '0;
         end
      endcase
   end

   // Data stand only in the cycle after the read strobe
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= req.rd ? next_rdata : 16'h0000;
      end
   end

endmodule : alwin_ctrl

/* alwin_params.svh */
// Offsets, field positions, reset values and widths of the alarm lock and alert control block
`ifndef ALWIN_PARAMS_SVH
`define ALWIN_PARAMS_SVH

// ----------------------------------------
// Bus widths
// ----------------------------------------
`define ALWIN_ADDR_W 8
`define ALWIN_DATA_W 16
`define ALWIN_TEMP_W 13
`define ALWIN_IRQ_W 3

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ALWIN_OFS_CONFIG 8'h01
`define ALWIN_OFS_UPPER 8'h02
`define ALWIN_OFS_LOWER 8'h03
`define ALWIN_OFS_CRIT 8'h04
`define ALWIN_OFS_TEMP 8'h05
`define ALWIN_OFS_SMBUS 8'h22
`define ALWIN_OFS_IRQ_STATUS 8'h30
`define ALWIN_OFS_IRQ_MASK 8'h31

// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define ALWIN_CFG_SHUTDOWN 8
`define ALWIN_CFG_CRIT_LOCK 7
`define ALWIN_CFG_WIN_LOCK 6
`define ALWIN_CFG_CLEAR 5
`define ALWIN_CFG_STATE 4
`define ALWIN_CFG_OUT_EN 3
`define ALWIN_CFG_CRIT_ONLY 2
`define ALWIN_CFG_POLARITY 1
`define ALWIN_CFG_INT_MODE 0

// ----------------------------------------
// Other fields
// ----------------------------------------
`define ALWIN_TEMP_ABOVE_CRIT 15
`define ALWIN_TEMP_ABOVE_UPPER 14
`define ALWIN_TEMP_BELOW_LOWER 13
`define ALWIN_SMBUS_ARA_SEL 0
`define ALWIN_IRQ_ALERT 0
`define ALWIN_IRQ_REFUSED 1
`define ALWIN_IRQ_CLEARED 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ALWIN_RST_TRIP 16'h0000
`define ALWIN_RST_SMBUS 1'h0

`endif

/* alwin_pkg.sv */
// Types shared by the alarm lock and alert control block
package alwin_pkg;

   // Stored configuration bits
   typedef struct packed {
      logic shutdown;
      logic crit_lock;
      logic win_lock;
      logic out_en;
      logic crit_only;
      logic polarity;
      logic int_mode;
   } alwin_cfg_t;

   // Trip conditions from the comparator logic
   typedef struct packed {
      logic above_crit;
      logic above_upper;
      logic below_lower;
   } alwin_trip_t;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } alwin_req_t;

endpackage : alwin_pkg

/* alwin_sync.sv */
// Three-stage synchroniser for an input from outside the clock domain
`timescale 1ns/1ns
module alwin_sync (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic async_in,
   output logic level
);

   logic meta;
   logic stage2;
   logic stage3;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
      end else if (ce) begin
         meta <= async_in;
         stage2 <= meta;
         stage3 <= stage2;
      end
   end

   // A change counts only once the last two stages agree
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         level <= 1'b0;
      end else if (ce && (stage2 == stage3)) begin
         level <= stage3;
      end
   end

endmodule : alwin_sync

/* alwin_irq.sv */
// Sticky interrupt status with write-one-to-clear, mask and level output
`timescale 1ns/1ns
module alwin_irq #(
   parameter int W = 3
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [W-1:0] event_set,
   input wire logic wr_status,
   input wire logic wr_mask,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] status,
   output logic [W-1:0] mask,
   output logic irq
);

   logic [W-1:0] next_status;

   // Set wins over a clear in the same cycle
   always_comb begin
      next_status = status;
      if (wr_status) begin
         next_status = status & ~wdata;
      end
      next_status = next_status | event_set;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         status <= '0;
      end else if (ce) begin
         status <= next_status;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mask <= '0;
      end else if (ce && wr_mask) begin
         mask <= wdata;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(next_status & mask);
      end
   end

endmodule : alwin_irq

/* alwin_ctrl_properties.sv */
// Concurrent checks on the ports of the alarm lock and alert control block
`include "alwin_params.svh"
`timescale 1ns/1ns
module alwin_ctrl_properties (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire alwin_pkg::alwin_trip_t trip,
   input wire logic [12:0] temp_value,
   input wire logic ara_detect,
   input wire logic alert_out,
   input wire logic alert_oe,
   input wire logic irq
);
   logic [1:0] locks;
   logic en_sh;
   logic pol_sh;
   logic sd_sh;
   logic [15:0] upper_sh;
   logic cfg_wr;
   assign cfg_wr = ce && wr && addr == `ALWIN_OFS_CONFIG;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------
   // Shadow of stored state, built from bus traffic only
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         locks <= 2'h0;
         en_sh <= 1'b0;
         pol_sh <= 1'b0;
         sd_sh <= 1'b0;
         upper_sh <= `ALWIN_RST_TRIP;
      end else begin
         if (cfg_wr) begin
            locks <= locks | wdata[7:6];
            en_sh <= (locks == 2'h0) ? wdata[3] : en_sh;
            pol_sh <= (locks == 2'h0) ? wdata[1] : pol_sh;
            sd_sh <= (locks == 2'h0) ? wdata[8] : (sd_sh & wdata[8]);
         end
         if (ce && wr && addr == `ALWIN_OFS_UPPER && !locks[0]) begin
            upper_sh <= wdata;
         end
      end
   end
   sequence s_rd(logic [7:0] a);
      ce && rd && addr == a;
   endsequence
   sequence s_lock_wr;
      cfg_wr && wdata[6];
   endsequence
   property p_clear_zero; s_rd(`ALWIN_OFS_CONFIG) |=> rdata[5] == 1'b0; endproperty
   a_clear_zero: assert property (p_clear_zero) else $error("clear bit read back nonzero");
   property p_lock_reads; s_rd(`ALWIN_OFS_CONFIG) ##0 locks[0] |=> rdata[6]; endproperty
   a_lock_reads: assert property (p_lock_reads) else $error("window lock lost");
   property p_lock_one_write; s_lock_wr ##[1:4] s_rd(`ALWIN_OFS_CONFIG) |=> rdata[6]; endproperty
   a_lock_one_write: assert property (p_lock_one_write) else $error("single write did not lock");
   property p_upper_frozen; s_rd(`ALWIN_OFS_UPPER) |=> rdata == $past(upper_sh); endproperty
   a_upper_frozen: assert property (p_upper_frozen) else $error("upper trip value wrong");
   property p_out_low; alert_out == 1'b0; endproperty
   a_out_low: assert property (p_out_low) else $error("alert data not low");
   property p_state; s_rd(`ALWIN_OFS_CONFIG) ##0 (en_sh && !pol_sh) |=> rdata[4] == $past(alert_oe); endproperty
   a_state: assert property (p_state) else $error("alert state bit differs from pin");
   property p_en_pol_held; s_rd(`ALWIN_OFS_CONFIG) |=> {rdata[3], rdata[1]} == $past({en_sh, pol_sh}); endproperty
   a_en_pol_held: assert property (p_en_pol_held) else $error("enable or polarity changed");
   property p_shutdown; s_rd(`ALWIN_OFS_CONFIG) |=> rdata[8] == $past(sd_sh); endproperty
   a_shutdown: assert property (p_shutdown) else $error("shutdown bit wrong");
endmodule : alwin_ctrl_properties
bind alwin_ctrl alwin_ctrl_properties u_props (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trip(trip), .temp_value(temp_value),
   .ara_detect(ara_detect), .alert_out(alert_out), .alert_oe(alert_oe), .irq(irq));

/* alwin_host_model.sv */
// Host side model that issues the alert response command after a chosen delay
`timescale 1ns/1ns
module alwin_host_model (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic send_ara,
   input wire logic [3:0] ara_delay,
   output logic ara_detect
);
   logic [4:0] cnt;
   // Command line raised after the delay, held four cycles, then released low
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 5'h00;
         ara_detect <= 1'b0;
      end else if (send_ara) begin
         cnt <= {1'b0, ara_delay} + 5'h05;
      end else if (cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
         ara_detect <= cnt < 5'h05;
      end else begin
         ara_detect <= 1'b0;
      end
   end
endmodule : alwin_host_model

/* tb_top.sv */
// Self-checking testbench of the alarm lock and alert control block
`include "alwin_params.svh"
`timescale 1ns/1ns
module tb_top;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic ce = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata;
   alwin_pkg::alwin_trip_t trip = 3'h0;
   logic [12:0] temp_value = 13'h0000;
   logic ara_detect;
   logic alert_out;
   logic alert_oe;
   logic irq;
   logic send_ara = 1'b0;
   logic [3:0] ara_delay = 4'h0;
   int mismatches = 0;
   int compares = 0;
   int seed = 32'ha7f3a81e;
   int m_cfg = 0;
   int m_upper;
   int lk_q[$] = '{16'h0000, 16'h0001, 16'h0104, 16'h0002};
   logic [15:0] v;
   always #50 ref_clk = ~ref_clk;
   alwin_ctrl dut (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .trip(trip), .temp_value(temp_value), .ara_detect(ara_detect),
      .alert_out(alert_out), .alert_oe(alert_oe), .irq(irq));
   alwin_host_model host (.ref_clk(ref_clk), .reset_n(reset_n), .send_ara(send_ara), .ara_delay(ara_delay),
      .ara_detect(ara_detect));
   task automatic report_and_stop;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rd_reg
   // ----------------------------------------
   // Reference model of the stored configuration under the locks
   // ----------------------------------------
   function automatic int cfg_next(int cur, int d);
      int n;
      n = ((cur | d) & 16'h00c0) | (d & 16'h0001);
      if ((cur & 16'h00c0) == 0) begin
         n = n | (d & 16'h010e);
      end else begin
         n = n | (cur & 16'h000a) | (d & cur & 16'h0100);
         n = n | ((((cur & 16'h0040) != 0) ? cur : d) & 16'h0004);
      end
      return n;
   endfunction : cfg_next
   task automatic set_cfg(input int d);
      m_cfg = cfg_next(m_cfg, d);
      wr_reg(`ALWIN_OFS_CONFIG, d[15:0]);
   endtask : set_cfg
   task automatic rd_cfg(input logic st);
      rd_reg(`ALWIN_OFS_CONFIG);
      check(v, m_cfg[15:0] | {11'h000, st, 4'h0});
   endtask : rd_cfg
   task automatic wait_oe(input logic exp);
      #1;
      for (int i = 0; i < 30 && alert_oe !== exp; i++) begin
         @(posedge ref_clk);
         #1;
      end
      check({15'h0000, alert_oe}, {15'h0000, exp});
      if (alert_oe !== exp) report_and_stop();
   endtask : wait_oe
   task automatic ara(input logic [3:0] dly);
      @(posedge ref_clk);
      ara_delay <= dly;
      send_ara <= 1'b1;
      @(posedge ref_clk);
      send_ara <= 1'b0;
   endtask : ara
   task automatic retrigger;
      @(posedge ref_clk);
      trip <= 3'h0;
      repeat (3) @(posedge ref_clk);
      trip <= 3'h2;
      wait_oe(1'b1);
   endtask : retrigger
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      temp_value <= 13'($random(seed));
      rd_cfg(1'b0);
      rd_reg(8'h7f);
      check(v, 16'h0000);
      m_upper = $random(seed) & 16'h0ffc;
      wr_reg(`ALWIN_OFS_UPPER, m_upper[15:0]);
      rd_reg(`ALWIN_OFS_UPPER);
      check(v, m_upper[15:0]);
      // A write while the clock enable is low must not land
      @(posedge ref_clk);
      ce <= 1'b0;
      wr_reg(`ALWIN_OFS_LOWER, ~m_upper[15:0]);
      ce <= 1'b1;
      rd_reg(`ALWIN_OFS_LOWER);
      check(v, 16'h0000);
      wr_reg(`ALWIN_OFS_LOWER, m_upper[15:0] ^ 16'h0ff0);
      rd_reg(`ALWIN_OFS_LOWER);
      check(v, m_upper[15:0] ^ 16'h0ff0);
      wr_reg(`ALWIN_OFS_IRQ_MASK, 16'h0007);
      set_cfg(16'h0009);
      @(posedge ref_clk);
      trip <= 3'h2;
      wait_oe(1'b1);
      rd_cfg(1'b1);
      check({15'h0000, irq}, 16'h0001);
      rd_reg(`ALWIN_OFS_TEMP);
      check(v, {3'h2, temp_value});
      wr_reg(`ALWIN_OFS_CONFIG, m_cfg[15:0] | 16'h0030);
      wait_oe(1'b0);
      rd_cfg(1'b0);
      rd_reg(`ALWIN_OFS_IRQ_STATUS);
      check(v, 16'h0005);
      wr_reg(`ALWIN_OFS_IRQ_STATUS, 16'h0007);
      for (int i = 0; i < 2; i++) begin
         retrigger();
         ara(4'(i * 7));
         wait_oe(1'b0);
      end
      wr_reg(`ALWIN_OFS_SMBUS, 16'h0001);
      retrigger();
      ara(4'h0);
      repeat (20) @(posedge ref_clk);
      #1;
      check({15'h0000, alert_oe}, 16'h0001);
      set_cfg(16'h0008);
      wr_reg(`ALWIN_OFS_CONFIG, 16'h0028);
      repeat (4) @(posedge ref_clk);
      trip <= 3'h0;
      #1;
      check({15'h0000, alert_oe}, 16'h0001);
      wait_oe(1'b0);
      // Active-high polarity pulls the line while idle
      set_cfg(16'h000a);
      wait_oe(1'b1);
      set_cfg(16'h0008);
      wait_oe(1'b0);
      wr_reg(`ALWIN_OFS_IRQ_STATUS, 16'h0007);
      set_cfg(16'h014c);
      rd_cfg(1'b0);
      wr_reg(`ALWIN_OFS_UPPER, ~m_upper[15:0] & 16'h0ffc);
      rd_reg(`ALWIN_OFS_UPPER);
      check(v, m_upper[15:0]);
      wr_reg(`ALWIN_OFS_LOWER, 16'h0000);
      rd_reg(`ALWIN_OFS_LOWER);
      check(v, m_upper[15:0] ^ 16'h0ff0);
      foreach (lk_q[i]) begin
         set_cfg(lk_q[i]);
         rd_cfg(1'b0);
      end
      rd_reg(`ALWIN_OFS_IRQ_STATUS);
      check(v, 16'h0002);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      m_cfg = 0;
      rd_cfg(1'b0);
      report_and_stop();
   end
endmodule : tb_top
